// >>> src/srt_top.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "srt_map.svh"
module srt_top (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [9:0]   address,
	input  wire logic         read,
	input  wire logic         write,
	input  wire logic [31:0]  writedata,
	input  wire logic [3:0]   byteenable,
	output logic [31:0]       readdata,
	output logic              waitrequest,
	output logic              irq,
	input  wire logic         sclk_in,
	output logic              sclk_out,
	output logic              sclk_oe,
	input  wire logic         mosi_in,
	output logic              mosi_out,
	output logic              mosi_oe,
	input  wire logic         miso_in,
	output logic              miso_out,
	output logic              miso_oe,
	input  wire logic         nss_in,
	output logic              nss_out,
	output logic              nss_oe
);
	import srt_pkg::*;

	localparam int OE_MAX   = `SRT_TSEZ_CYC;
	localparam int TAIL_MIN = `SRT_TSLH_CYC;
	localparam int TAIL_MAX = `SRT_TSLH_MAX_CYC;
	localparam logic [3:0] TAIL_LAST = 4'(`SRT_TSLH_CYC - 1);

	logic [1:0]  rst_q;
	logic        rst_n;
	srt_state_t  s;
	srt_state_t  n;
	logic        tick;
	logic [7:0]  idx;
	logic        req;
	logic        wr_go;
	logic        wr_data;
	logic        busy;
	logic        sel;
	logic        slave_on;
	logic        m_edge;
	logic        edge_ev;
	logic        lead;
	logic        sample;
	logic        din;
	logic        last_edge;
	logic        tail_load;
	logic        nss_fell;
	logic        nss_rose;
	logic        m_start;

	// reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	srt_clkdiv #(
		.W(8)
	) u_div (
		.clk  (clk),
		.rst_n(rst_n),
		.en   (s.en && s.master && (s.ph == PH_RUN)),
		.div  (s.div),
		.tick (tick)
	);

	always_comb begin
		idx       = address[9:2];
		req       = read || write;
		wr_go     = write && s.ack && byteenable[0];
		wr_data   = wr_go && (idx == `SRT_IDX_DATA);
		busy      = (s.ph != PH_IDLE);
		sel       = (s.nssmd != 2'h1) || !nss_in;
		slave_on  = s.en && !s.master && sel;
		nss_fell  = s.nss_prev && !nss_in && (s.nssmd == 2'h1);
		nss_rose  = !s.nss_prev && nss_in && (s.nssmd == 2'h1);
		m_edge    = s.en && s.master && (s.ph == PH_RUN) && tick;
		edge_ev   = s.master ? m_edge : (slave_on && (sclk_in != s.sclk_prev)
			&& (s.ph != PH_TAIL));
		lead      = s.master ? !s.lvl : (sclk_in ^ s.cpol);
		sample    = lead ^ s.cpha;
		din       = s.master ? miso_in : mosi_in;
		last_edge = edge_ev && (s.edge_cnt == (`SRT_EDGES - 5'h1));
		tail_load = (s.ph == PH_TAIL) && (s.tail_cnt == TAIL_LAST);
		m_start   = wr_data && !busy && s.en && s.master;

		n           = s;
		n.sclk_prev = sclk_in;
		n.nss_prev  = nss_in;
		n.oe        = slave_on;
		n.gap       = m_edge ? 9'h000 : 9'(s.gap + 9'h001);

		// bus slave: request seen, answer one cycle later
		n.ack = req && !s.ack;
		if (req && !s.ack) begin
			case (idx)
				`SRT_IDX_CTRL: begin
					n.rdata = {26'h0, s.nssmd, s.cpha, s.cpol, s.master, s.en};
				end
				`SRT_IDX_STATUS: begin
					n.rdata = {28'h0, busy, s.transmit_buffer_empty_flag, s.flag_write_collision_flag, s.flag_done};
				end
				`SRT_IDX_DIV: begin
					n.rdata = {24'h0, s.div};
				end
				`SRT_IDX_DATA: begin
					n.rdata = {24'h0, s.rxbuf};
				end
				`SRT_IDX_MASK: begin
					n.rdata = {30'h0, s.mask};
				end
				default: begin
					n.rdata = 32'h0;
				end
			endcase
		end

		if (wr_go) begin
			case (idx)
				`SRT_IDX_CTRL: begin
					n.en     = writedata[`SRT_CTRL_EN];
					n.master = writedata[`SRT_CTRL_MASTER];
					n.cpol   = writedata[`SRT_CTRL_CPOL];
					n.cpha   = writedata[`SRT_CTRL_CPHA];
					n.nssmd  = writedata[`SRT_CTRL_NSS_HI:`SRT_CTRL_NSS_LO];
				end
				`SRT_IDX_STATUS: begin
					if (writedata[`SRT_ST_DONE]) begin
						n.flag_done = 1'b0;
					end
					if (writedata[`SRT_ST_WRITE_COLLISION_FLAG]) begin
						n.flag_write_collision_flag = 1'b0;
					end
				end
				`SRT_IDX_DIV: begin
					n.div = writedata[7:0];
				end
				`SRT_IDX_MASK: begin
					n.mask = writedata[1:0];
				end
				default: begin
				end
			endcase
		end

		if (wr_data) begin
			if (busy) begin
				n.flag_write_collision_flag = 1'b1;
			end else begin
				n.txbuf = writedata[7:0];
				n.sr    = writedata[7:0];
				n.transmit_buffer_empty_flag = 1'b0;
				if (s.en && s.master) begin
					n.ph       = PH_RUN;
					n.lvl      = 1'b0;
					n.edge_cnt = 5'h00;
					n.transmit_buffer_empty_flag    = 1'b1;
				end
			end
		end

		if (!s.master && nss_fell) begin
			n.sr       = s.txbuf;
			n.edge_cnt = 5'h00;
		end

		if (edge_ev) begin
			if (!s.master && (s.ph == PH_IDLE)) begin
				n.ph    = PH_RUN;
				n.transmit_buffer_empty_flag = 1'b1;
			end
			if (s.master) begin
				n.lvl = !s.lvl;
			end
			if (sample) begin
				n.rxsr = {s.rxsr[6:0], din};
			end else if (!(s.cpha && (s.edge_cnt == 5'h00))) begin
				n.sr = {s.sr[6:0], 1'b0};
			end
			n.edge_cnt = 5'(s.edge_cnt + 5'h01);
			if (last_edge) begin
				n.edge_cnt  = 5'h00;
				n.rxbuf     = n.rxsr;
				n.flag_done = 1'b1;
				if (s.master || !s.cpha) begin
					n.ph = PH_IDLE;
					if (!s.master) begin
						n.sr = s.txbuf;
					end
				end else begin
					n.ph       = PH_TAIL;
					n.tail_cnt = 4'h0;
				end
			end
		end

		if (s.ph == PH_TAIL) begin
			n.tail_cnt = 4'(s.tail_cnt + 4'h1);
			if (tail_load) begin
				n.sr = s.txbuf;
				n.ph = PH_IDLE;
			end
		end

		if (!s.en || (!s.master && (nss_rose || !sel))) begin
			if (!s.master || !s.en) begin
				n.ph       = PH_IDLE;
				n.edge_cnt = 5'h00;
				n.lvl      = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s           <= '0;
			s.nssmd     <= `SRT_NSSMD_RESET;
			s.div       <= `SRT_DIV_RESET;
			s.txbuf     <= `SRT_DATA_RESET;
			s.rxbuf     <= `SRT_DATA_RESET;
			s.transmit_buffer_empty_flag     <= 1'b1;
			s.ph        <= PH_IDLE;
			s.sclk_prev <= 1'b0;
			s.nss_prev  <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign waitrequest = req && !s.ack;
	assign readdata    = s.rdata;
	assign irq         = |({s.flag_write_collision_flag, s.flag_done} & s.mask);
	assign sclk_out    = s.lvl ^ s.cpol;
	assign sclk_oe     = s.en && s.master;
	assign mosi_out    = s.sr[7];
	assign mosi_oe     = s.en && s.master;
	assign miso_out    = s.sr[7];
	assign miso_oe     = s.oe;
	assign nss_out     = s.nssmd[0];
	assign nss_oe      = s.en && s.nssmd[1];

	sequence seq_run8;
		(s.ph == PH_RUN) [*8];
	endsequence

	sequence seq_byte;
		seq_run8 ##1 seq_run8 ##1 (s.ph == PH_IDLE);
	endsequence

	a_sclk_period: assert property (@(posedge clk) disable iff (!rst_n)
		m_edge && (s.edge_cnt != 5'h00) |-> (s.gap == {1'b0, s.div}))
		else $error("master clock half period wrong");
	a_slave_nodiv: assert property (@(posedge clk) disable iff (!rst_n)
		!s.master |-> !tick)
		else $error("divider runs in slave mode");
	a_write_start: assert property (@(posedge clk) disable iff (!rst_n)
		m_start |=> (s.ph == PH_RUN) && (s.sr == $past(writedata[7:0])))
		else $error("master write did not start transfer");
	a_read_rx: assert property (@(posedge clk) disable iff (!rst_n)
		read && !s.ack && (idx == `SRT_IDX_DATA) |=> readdata == {24'h0, $past(s.rxbuf)})
		else $error("data read not from receive buffer");
	a_idle_polar: assert property (@(posedge clk) disable iff (!rst_n)
		s.master && (s.ph == PH_IDLE) |-> sclk_out == s.cpol)
		else $error("idle clock level wrong");
	a_miso_drive: assert property (@(posedge clk) disable iff (!rst_n)
		s.en && !s.master && (s.nssmd == 2'h1) && $fell(nss_in) |-> ##[1:OE_MAX] miso_oe)
		else $error("slave output not driven in time");
	a_miso_release: assert property (@(posedge clk) disable iff (!rst_n)
		(s.nssmd == 2'h1) && $rose(nss_in) |-> ##[1:OE_MAX] !miso_oe)
		else $error("slave output not released in time");
	a_shift_out: assert property (@(posedge clk) disable iff (!rst_n)
		edge_ev && !s.master && !sample && !(s.cpha && (s.edge_cnt == 5'h00))
		|=> miso_out == ($past(last_edge) ? $past(s.txbuf[7]) : $past(s.sr[6])))
		else $error("slave output not shifted");
	a_tail_delay: assert property (@(posedge clk) disable iff (!rst_n)
		last_edge && !s.master && s.cpha |-> !tail_load [*6] ##1 (tail_load || !sel))
		else $error("tail reload at wrong time");
	a_tail_bound: assert property (@(posedge clk) disable iff (!rst_n)
		last_edge && !s.master && s.cpha |-> ##[TAIL_MIN:TAIL_MAX] (s.ph == PH_IDLE))
		else $error("tail not finished in window");
	a_done_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		s.flag_done && !(wr_go && (idx == `SRT_IDX_STATUS) && writedata[0]) |=> s.flag_done)
		else $error("done flag lost");
	a_write_collision_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		wr_data && busy |=> s.flag_write_collision_flag && (irq == s.mask[1] || s.flag_done))
		else $error("collision not flagged");
	a_transmit_buffer_empty_flag_clr: assert property (@(posedge clk) disable iff (!rst_n)
		wr_data && !busy && !(s.en && s.master) |=> !s.transmit_buffer_empty_flag)
		else $error("buffer empty flag not cleared");
	a_byte_len: assert property (@(posedge clk) disable iff (!rst_n)
		m_start && (s.div == 8'h00) |=> seq_byte)
		else $error("master transfer length wrong");
endmodule : srt_top

// >>> shared/srt_map.svh
`ifndef SRT_MAP_SVH
`define SRT_MAP_SVH

// register indices; byte address is four times the index
`define SRT_IDX_CTRL     8'ha0
`define SRT_IDX_STATUS   8'ha1
`define SRT_IDX_DIV      8'ha2
`define SRT_IDX_DATA     8'ha3
`define SRT_IDX_MASK     8'ha4

// control fields
`define SRT_CTRL_EN      0
`define SRT_CTRL_MASTER  1
`define SRT_CTRL_CPOL    2
`define SRT_CTRL_CPHA    3
`define SRT_CTRL_NSS_LO  4
`define SRT_CTRL_NSS_HI  5
`define SRT_NSSMD_RESET  2'h1

// status fields
`define SRT_ST_DONE      0
`define SRT_ST_WRITE_COLLISION_FLAG      1
`define SRT_ST_TRANSMIT_BUFFER_EMPTY_FLAG     2
`define SRT_ST_BUSY      3

`define SRT_DIV_RESET    8'h00
`define SRT_DATA_RESET   8'h00
`define SRT_EDGES        5'h10

// timing
`define SRT_CLK_NS       25
`define SRT_TSEZ_NS      100
`define SRT_TSLH_MIN_NS  150
`define SRT_TSLH_MAX_NS  200
`define SRT_TSEZ_CYC     (`SRT_TSEZ_NS / `SRT_CLK_NS)
`define SRT_TSLH_CYC     ((`SRT_TSLH_MIN_NS + `SRT_CLK_NS - 1) / `SRT_CLK_NS)
`define SRT_TSLH_MAX_CYC (`SRT_TSLH_MAX_NS / `SRT_CLK_NS)
`endif

// >>> shared/srt_pkg.sv
package srt_pkg;
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_RUN,
		PH_TAIL
	} srt_phase_t;

	typedef struct packed {
		logic        en;
		logic        master;
		logic        cpol;
		logic        cpha;
		logic [1:0]  nssmd;
		logic [7:0]  div;
		logic [7:0]  txbuf;
		logic [7:0]  rxbuf;
		logic [7:0]  sr;
		logic [7:0]  rxsr;
		logic        flag_done;
		logic        flag_write_collision_flag;
		logic [1:0]  mask;
		logic        transmit_buffer_empty_flag;
		srt_phase_t  ph;
		logic [4:0]  edge_cnt;
		logic        lvl;
		logic [3:0]  tail_cnt;
		logic        sclk_prev;
		logic        nss_prev;
		logic        oe;
		logic        ack;
		logic [31:0] rdata;
		logic [8:0]  gap;
	} srt_state_t;
endpackage : srt_pkg

// >>> src/srt_clkdiv.sv
`timescale 1ns/10ps
`include "srt_map.svh"
module srt_clkdiv #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         en,
	input  wire logic [W-1:0] div,
	output logic              tick
);
	import srt_pkg::*;
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	always_comb begin
		tick = en && (cnt == div);
		if (!en || tick) begin
			next_cnt = '0;
		end else begin
			next_cnt = cnt + W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	a_tick_gated: assert property (@(posedge clk) disable iff (!rst_n) !en |-> !tick)
		else $error("divider ticks while disabled");
endmodule : srt_clkdiv

// >>> sim/srt_slave_model.sv
`timescale 1ns/10ps
module srt_slave_model (
	input  wire logic       sclk,
	input  wire logic       nss_n,
	input  wire logic       mosi,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic [7:0]      rx_byte
);
	logic [7:0] sr;

	initial begin
		sr = 8'h00;
		rx_byte = 8'h00;
	end
	// byte loaded when selected; first bit out before any edge
	always @(negedge nss_n) begin
		sr = tx_byte;
	end
	// leading edge samples, trailing edge shifts, msb first
	always @(posedge sclk) begin
		if (!nss_n) rx_byte = {rx_byte[6:0], mosi};
	end
	always @(negedge sclk) begin
		if (!nss_n) sr = {sr[6:0], 1'b0};
	end
	// deselected line shows the inverse of the last bit
	assign miso = nss_n ? ~sr[7] : sr[7];
endmodule : srt_slave_model

// >>> sim/testbench.sv
`timescale 1ns/10ps
`include "srt_map.svh"
module testbench;
	logic        clk, nrst, read, write, sclk_in, mosi_in, nss_in;
	logic [9:0]  address;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  byteenable;
	logic        waitrequest, irq, sclk_out, sclk_oe, mosi_out, mosi_oe;
	logic        miso_m, miso_out, miso_oe, nss_out, nss_oe;
	logic [7:0]  slv_tx, slv_rx, b;
	int          num_errors, comparisons, n;

	srt_top srt_top_inst (.clk(clk), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .irq(irq), .sclk_in(sclk_in),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_m), .miso_out(miso_out), .miso_oe(miso_oe),
		.nss_in(nss_in), .nss_out(nss_out), .nss_oe(nss_oe));
	srt_slave_model srt_slave_model_inst (.sclk(sclk_out), .nss_n(nss_out),
		.mosi(mosi_out), .tx_byte(slv_tx), .miso(miso_m), .rx_byte(slv_rx));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50) num_errors++;
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// bench acts as external master towards the slave port
	task automatic spi_xfer(input logic cpha, input logic [7:0] mo, output logic [7:0] mi);
		mi = 8'h00;
		nss_in <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 7; i >= 0; i--) begin
			if (cpha) begin
				sclk_in <= ~sclk_in;
				repeat (6) @(posedge clk);
			end
			mosi_in <= mo[i];
			repeat (3) @(posedge clk);
			mi[i] = miso_out;
			sclk_in <= ~sclk_in;
			if (cpha && i == 0) break;
			repeat (6) @(posedge clk);
			if (!cpha) begin
				sclk_in <= ~sclk_in;
				repeat (3) @(posedge clk);
			end
		end
	endtask : spi_xfer

	task automatic wait_chg(ref logic s);
		logic p;
		p = s;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (s === p && n < 600);
	endtask : wait_chg

	task wait_idle();
		int k;
		k = 0;
		do begin
			bus(1'b0, `SRT_IDX_STATUS, 8'h00);
			k++;
		end while (q[3] !== 1'b0 && k < 100);
	endtask : wait_idle

	task give_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#(25 * 20000);
		num_errors++;
		give_verdict();
	end

	initial begin
		num_errors = 0;
		comparisons = 0;
		nrst = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 10'h000;
		writedata = 32'h0;
		byteenable = 4'hf;
		sclk_in = 1'b0;
		mosi_in = 1'b0;
		nss_in = 1'b1;
		slv_tx = 8'h3c;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1'b0, `SRT_IDX_DIV, 8'h00);
		chk(q, 32'h0);
		bus(1'b0, `SRT_IDX_DATA, 8'h00);
		chk(q, 32'h0);
		bus(1'b0, `SRT_IDX_STATUS, 8'h00);
		chk(q, 32'h4);
		bus(1'b0, `SRT_IDX_CTRL, 8'h00);
		chk(q, 32'h10);
		bus(1'b0, 8'hb0, 8'h00);
		chk(q, 32'h0);
		bus(1'b1, `SRT_IDX_DIV, 8'h01);
		bus(1'b1, `SRT_IDX_MASK, 8'h03);
		bus(1'b1, `SRT_IDX_CTRL, 8'h23);
		@(negedge clk);
		chk(nss_oe, 1);
		chk(nss_out, 0);
		chk(mosi_oe, 1);
		bus(1'b1, `SRT_IDX_DATA, 8'ha5);
		wait_chg(sclk_out);
		wait_chg(sclk_out);
		chk(n, 2);
		wait_idle();
		bus(1'b0, `SRT_IDX_DATA, 8'h00);
		chk(q, 32'h3c);
		chk(slv_rx, 8'ha5);
		bus(1'b0, `SRT_IDX_STATUS, 8'h00);
		chk(q, 32'h5);
		chk(irq, 1);
		bus(1'b1, `SRT_IDX_STATUS, 8'h03);
		@(negedge clk);
		chk(irq, 0);
		bus(1'b1, `SRT_IDX_DIV, 8'h00);
		// second write lands mid-transfer
		bus(1'b1, `SRT_IDX_DATA, 8'h81);
		bus(1'b1, `SRT_IDX_DATA, 8'h7e);
		bus(1'b0, `SRT_IDX_STATUS, 8'h00);
		chk(q & 32'h2, 32'h2);
		chk(irq, 1);
		bus(1'b1, `SRT_IDX_MASK, 8'h00);
		@(negedge clk);
		chk(irq, 0);
		wait_idle();
		chk(q, 32'h7);
		bus(1'b1, `SRT_IDX_STATUS, 8'h03);
		bus(1'b0, `SRT_IDX_STATUS, 8'h00);
		chk(q, 32'h4);
		bus(1'b1, `SRT_IDX_CTRL, 8'h27);
		repeat (2) @(negedge clk);
		chk(sclk_out, 1);
		bus(1'b1, `SRT_IDX_CTRL, 8'h11);
		repeat (2) @(negedge clk);
		chk(sclk_oe, 0);
		chk(miso_oe, 0);
		@(posedge clk);
		nss_in <= 1'b0;
		wait_chg(miso_oe);
		chk(n <= 4, 1);
		@(posedge clk);
		nss_in <= 1'b1;
		wait_chg(miso_oe);
		chk(n <= 4, 1);
		chk(miso_oe, 0);
		bus(1'b1, `SRT_IDX_DATA, 8'h5a);
		spi_xfer(1'b0, 8'hc3, b);
		nss_in <= 1'b1;
		chk(b, 8'h5a);
		bus(1'b0, `SRT_IDX_DATA, 8'h00);
		chk(q, 32'hc3);
		bus(1'b0, `SRT_IDX_STATUS, 8'h00);
		chk(q, 32'h5);
		bus(1'b1, `SRT_IDX_STATUS, 8'h03);
		bus(1'b1, `SRT_IDX_CTRL, 8'h1d);
		sclk_in <= 1'b1;
		bus(1'b1, `SRT_IDX_DATA, 8'h96);
		spi_xfer(1'b1, 8'h69, b);
		wait_chg(miso_out);
		chk(n >= 7 && n <= 9, 1);
		@(posedge clk);
		nss_in <= 1'b1;
		chk(b, 8'h96);
		bus(1'b0, `SRT_IDX_DATA, 8'h00);
		chk(q, 32'h69);
		bus(1'b1, `SRT_IDX_CTRL, 8'h01);
		repeat (2) @(negedge clk);
		chk(miso_oe, 1);
		chk(nss_oe, 0);
		give_verdict();
	end
endmodule : testbench
